// [include/pci_regs.vh]
// register map, field positions and reset values of the pin change interrupt unit
`ifndef PCI_REGS_VH
`define PCI_REGS_VH
// Summary of operation
// - type bit: 0 level, 1 edge; grouped 67,45
// - port select bits 1:0 pick port 0..3
// - negative enable: low level or falling edge
// - positive enable: high level or rising edge
// - edge mode: hardware sets flag on enabled edge
// - level mode: flag shows inverted pin level
// - level flag read-only; edge flag read/write
// - priority low bit 1 plus high bit
// - priority low byte holds seven other sources
// - all registers clear to zero at reset

// register indices; byte address is four times the index
`define PCI_IDX_CONTROL 8'hE9
`define PCI_IDX_NEG_EN 8'hEA
`define PCI_IDX_POS_EN 8'hEB
`define PCI_IDX_FLAGS 8'hEC
`define PCI_IDX_PRIO_LOW 8'hEF
`define PCI_IDX_PRIO_HIGH 8'h80
`define PCI_IDX_IRQ_STATUS 8'h81
`define PCI_IDX_IRQ_CLEAR 8'h82
`define PCI_IDX_IRQ_ENABLE 8'h83

// byte addresses on the 12-bit apb address
`define PCI_ADDR_CONTROL {2'h0, `PCI_IDX_CONTROL, 2'h0}
`define PCI_ADDR_NEG_EN {2'h0, `PCI_IDX_NEG_EN, 2'h0}
`define PCI_ADDR_POS_EN {2'h0, `PCI_IDX_POS_EN, 2'h0}
`define PCI_ADDR_FLAGS {2'h0, `PCI_IDX_FLAGS, 2'h0}
`define PCI_ADDR_PRIO_LOW {2'h0, `PCI_IDX_PRIO_LOW, 2'h0}
`define PCI_ADDR_PRIO_HIGH {2'h0, `PCI_IDX_PRIO_HIGH, 2'h0}
`define PCI_ADDR_IRQ_STATUS {2'h0, `PCI_IDX_IRQ_STATUS, 2'h0}
`define PCI_ADDR_IRQ_CLEAR {2'h0, `PCI_IDX_IRQ_CLEAR, 2'h0}
`define PCI_ADDR_IRQ_ENABLE {2'h0, `PCI_IDX_IRQ_ENABLE, 2'h0}

// control register fields
`define PCI_PORT_SEL_MSB 1
`define PCI_PORT_SEL_LSB 0
`define PCI_TYPE_CH0_BIT 2
`define PCI_TYPE_CH1_BIT 3
`define PCI_TYPE_CH2_BIT 4
`define PCI_TYPE_CH3_BIT 5
`define PCI_TYPE_CH45_BIT 6
`define PCI_TYPE_CH67_BIT 7

// port select codes
`define PCI_PORT0 2'h0
`define PCI_PORT1 2'h1
`define PCI_PORT2 2'h2
`define PCI_PORT3 2'h3

// priority low byte fields
`define PCI_PRIO_TIMER2_BIT 7
`define PCI_PRIO_SPI_BIT 6
`define PCI_PRIO_BRAKE_BIT 5
`define PCI_PRIO_WDOG_BIT 4
`define PCI_PRIO_PWM_BIT 3
`define PCI_PRIO_CAPTURE_BIT 2
`define PCI_PRIO_PIN_BIT 1
`define PCI_PRIO_I2C_BIT 0

// reset values
`define PCI_RST_BYTE 8'h00
`define PCI_RST_WORD 32'h00000000

`endif

// [hdl/pci_sync.v]
// two-flop synchroniser bank for the 32 port pins
module pci_sync (
    input wire clk,
    input wire reset,
    input wire [31:0] asyncIn,
    output wire [31:0] syncOut
);

    // first stage, read only by the second stage
    reg [31:0] meta_ff;
    // second stage, safe to use in logic
    reg [31:0] stable_ff;

    genvar i;
    generate
        for (i = 0; i < 32; i = i + 1) begin : gBit
            // one synchroniser per pin
            always @(posedge clk) begin
                if (reset) begin
                    meta_ff[i] <= 1'h0;
                    stable_ff[i] <= 1'h0;
                end else begin
                    meta_ff[i] <= asyncIn[i];
                    stable_ff[i] <= meta_ff[i];
                end
            end
        end
    endgenerate

    assign syncOut = stable_ff;

endmodule

// [hdl/pci_top.v]
// pin change interrupt unit with apb register access
`include "pci_regs.vh"

module pci_top (
    input wire clk,
    input wire reset,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // the four candidate ports, asynchronous
    input wire [7:0] port0Pins,
    input wire [7:0] port1Pins,
    input wire [7:0] port2Pins,
    input wire [7:0] port3Pins,
    // pin source request and its priority level
    output reg pinIrqReq,
    output reg [1:0] pinIrqPriority,
    // priority low bits of the other sources
    output reg [7:0] priorityLowOut,
    // summary interrupt from sticky status
    output reg irq
);

    // control: type bits and port select
    reg [7:0] pinIrqControl_ff;
    // falling edge / low level enables
    reg [7:0] negEnable_ff;
    // rising edge / high level enables
    reg [7:0] posEnable_ff;
    // channel flags
    reg [7:0] channelFlag_ff;
    // priority low and high bytes
    reg [7:0] prioLow_ff;
    reg [7:0] prioHigh_ff;
    // sticky event status and its enables
    reg [7:0] irqStatus_ff;
    reg [7:0] irqEnable_ff;
    // previous sample of the selected port
    reg [7:0] prevPins_ff;
    // port select seen in the previous cycle
    reg [1:0] lastSel_ff;
    // per channel request of the previous cycle
    reg [7:0] chanReq_ff;
    // apb answer registers and registered outputs
    reg [31:0] prdata_ff;
    reg pready_ff;
    reg pslverr_ff;
    reg pinIrqReq_ff;
    reg [1:0] pinIrqPriority_ff;
    reg irq_ff;

    // synchronised pins, all four ports
    wire [31:0] syncPins;
    // selected port after synchronisation
    reg [7:0] selPins;
    // per channel edge mode
    wire [7:0] edgeMode;
    // per channel next flag, request and events
    wire [7:0] nxt_channelFlag;
    wire [7:0] nxt_chanReq;
    wire [7:0] nxt_irqStatus;
    // edge detection allowed this cycle
    wire edgeValid;
    // apb decode
    wire accessPhase;
    wire wrStrobe;
    reg addrHit;
    reg [7:0] readByte;

    // every pin passes two flops before use
    pci_sync uSync (
        .clk(clk),
        .reset(reset),
        .asyncIn({port3Pins, port2Pins, port1Pins, port0Pins}),
        .syncOut(syncPins)
    );

    // port multiplexer driven by the select field
    always @* begin
        case (pinIrqControl_ff[`PCI_PORT_SEL_MSB:`PCI_PORT_SEL_LSB])
            `PCI_PORT0: selPins = syncPins[7:0];
            `PCI_PORT1: selPins = syncPins[15:8];
            `PCI_PORT2: selPins = syncPins[23:16];
            default: selPins = syncPins[31:24];
        endcase
    end

    // type bits spread out to the eight channels; channels 4,5 and 6,7 share one bit per pair
    assign edgeMode = {
        pinIrqControl_ff[`PCI_TYPE_CH67_BIT], pinIrqControl_ff[`PCI_TYPE_CH67_BIT],
        pinIrqControl_ff[`PCI_TYPE_CH45_BIT], pinIrqControl_ff[`PCI_TYPE_CH45_BIT],
        pinIrqControl_ff[`PCI_TYPE_CH3_BIT], pinIrqControl_ff[`PCI_TYPE_CH2_BIT],
        pinIrqControl_ff[`PCI_TYPE_CH1_BIT], pinIrqControl_ff[`PCI_TYPE_CH0_BIT]
    };

    // after a port switch the old sample belongs to another port,
    // so one cycle of edges is ignored to avoid false triggers
    assign edgeValid = (lastSel_ff == pinIrqControl_ff[`PCI_PORT_SEL_MSB:`PCI_PORT_SEL_LSB]);

    // write takes effect at the edge where pready is sampled high
    assign accessPhase = psel & penable;
    assign wrStrobe = accessPhase & pready_ff & pwrite & addrHit;

    // per channel detection, flag and event logic
    genvar ch;
    generate
        for (ch = 0; ch < 8; ch = ch + 1) begin : gChan
            // edge seen between two consecutive samples
            wire rise = edgeValid & selPins[ch] & ~prevPins_ff[ch];
            wire fall = edgeValid & ~selPins[ch] & prevPins_ff[ch];
            // enabled edge of either polarity
            wire edgeHit = (posEnable_ff[ch] & rise) | (negEnable_ff[ch] & fall);
            // enabled level condition
            wire levelHit = (posEnable_ff[ch] & selPins[ch]) | (negEnable_ff[ch] & ~selPins[ch]);
            // software write to the flag, edge mode only
            wire flagWr = wrStrobe & (paddr == `PCI_ADDR_FLAGS) & edgeMode[ch];
            // software value for this flag, or the held one
            wire swFlag = flagWr ? pwdata[ch] : channelFlag_ff[ch];
            // level: inverse of pin; edge: hardware set beats software
            assign nxt_channelFlag[ch] = edgeMode[ch] ? (swFlag | edgeHit) : ~selPins[ch];
            // request: edge flag, or enabled level condition
            assign nxt_chanReq[ch] = edgeMode[ch] ? nxt_channelFlag[ch] : levelHit;
            // a new request sets status; set wins over clear
            assign nxt_irqStatus[ch] = (nxt_chanReq[ch] & ~chanReq_ff[ch]) |
                (irqStatus_ff[ch] & ~(wrStrobe & (paddr == `PCI_ADDR_IRQ_CLEAR) & pwdata[ch]));
        end
    endgenerate

    // address decode, aligned words only
    always @* begin
        addrHit = 1'b1;
        readByte = `PCI_RST_BYTE;
        if (paddr == `PCI_ADDR_CONTROL) begin
            readByte = pinIrqControl_ff;
        end else if (paddr == `PCI_ADDR_NEG_EN) begin
            readByte = negEnable_ff;
        end else if (paddr == `PCI_ADDR_POS_EN) begin
            readByte = posEnable_ff;
        end else if (paddr == `PCI_ADDR_FLAGS) begin
            readByte = channelFlag_ff;
        end else if (paddr == `PCI_ADDR_PRIO_LOW) begin
            readByte = prioLow_ff;
        end else if (paddr == `PCI_ADDR_PRIO_HIGH) begin
            readByte = prioHigh_ff;
        end else if (paddr == `PCI_ADDR_IRQ_STATUS) begin
            readByte = irqStatus_ff;
        end else if (paddr == `PCI_ADDR_IRQ_CLEAR) begin
            // write-only, reads zero
            readByte = `PCI_RST_BYTE;
        end else if (paddr == `PCI_ADDR_IRQ_ENABLE) begin
            readByte = irqEnable_ff;
        end else begin
            // unmapped: error answer, zero data
            addrHit = 1'b0;
        end
    end

    // apb handshake: one wait state, answer in second access cycle
    always @(posedge clk) begin
        if (reset) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= `PCI_RST_WORD;
        end else begin
            pready_ff <= accessPhase & ~pready_ff;
            if (accessPhase & ~pready_ff) begin
                // data captured one cycle before pready is seen
                pslverr_ff <= ~addrHit;
                prdata_ff <= {24'h000000, readByte};
            end else begin
                pslverr_ff <= 1'b0;
                prdata_ff <= `PCI_RST_WORD;
            end
        end
    end

    // software written configuration registers
    always @(posedge clk) begin
        if (reset) begin
            pinIrqControl_ff <= `PCI_RST_BYTE;
            negEnable_ff <= `PCI_RST_BYTE;
            posEnable_ff <= `PCI_RST_BYTE;
            prioLow_ff <= `PCI_RST_BYTE;
            prioHigh_ff <= `PCI_RST_BYTE;
            irqEnable_ff <= `PCI_RST_BYTE;
        end else if (wrStrobe) begin
            // only the low byte lane carries data
            if (paddr == `PCI_ADDR_CONTROL) begin
                pinIrqControl_ff <= pwdata[7:0];
            end else if (paddr == `PCI_ADDR_NEG_EN) begin
                negEnable_ff <= pwdata[7:0];
            end else if (paddr == `PCI_ADDR_POS_EN) begin
                posEnable_ff <= pwdata[7:0];
            end else if (paddr == `PCI_ADDR_PRIO_LOW) begin
                prioLow_ff <= pwdata[7:0];
            end else if (paddr == `PCI_ADDR_PRIO_HIGH) begin
                prioHigh_ff <= pwdata[7:0];
            end else if (paddr == `PCI_ADDR_IRQ_ENABLE) begin
                irqEnable_ff <= pwdata[7:0];
            end
        end
    end

    // flags, samples, status and request state
    always @(posedge clk) begin
        if (reset) begin
            channelFlag_ff <= `PCI_RST_BYTE;
            prevPins_ff <= `PCI_RST_BYTE;
            lastSel_ff <= `PCI_PORT0;
            chanReq_ff <= `PCI_RST_BYTE;
            irqStatus_ff <= `PCI_RST_BYTE;
        end else begin
            channelFlag_ff <= nxt_channelFlag;
            prevPins_ff <= selPins;
            lastSel_ff <= pinIrqControl_ff[`PCI_PORT_SEL_MSB:`PCI_PORT_SEL_LSB];
            chanReq_ff <= nxt_chanReq;
            irqStatus_ff <= nxt_irqStatus;
        end
    end

    // registered outputs toward the core
    always @(posedge clk) begin
        if (reset) begin
            pinIrqReq_ff <= 1'b0;
            pinIrqPriority_ff <= 2'h0;
            irq_ff <= 1'b0;
        end else begin
            // request stays while any channel requests
            pinIrqReq_ff <= |nxt_chanReq;
            // high bit from the high byte, low bit from the low byte
            pinIrqPriority_ff <= {prioHigh_ff[`PCI_PRIO_PIN_BIT], prioLow_ff[`PCI_PRIO_PIN_BIT]};
            // level interrupt while an enabled status bit is set
            irq_ff <= |(nxt_irqStatus & irqEnable_ff);
        end
    end

    // every output straight from a flop
    always @* begin
        prdata = prdata_ff;
        pready = pready_ff;
        pslverr = pslverr_ff;
        pinIrqReq = pinIrqReq_ff;
        pinIrqPriority = pinIrqPriority_ff;
        priorityLowOut = prioLow_ff;
        irq = irq_ff;
    end

endmodule

// [test/pci_top_sva.sv]
// port level assertions for the pin change interrupt unit
`include "pci_regs.vh"
module pci_top_sva (
    input wire clk,
    input wire reset,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire pinIrqReq,
    input wire [1:0] pinIrqPriority,
    input wire [7:0] priorityLowOut,
    input wire irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // completed write as the master sees it
    wire wrDone = psel && penable && pready && pwrite && !pslverr;
    // low byte and bit 1 of write data, kept as plain signals for $past
    wire [7:0] lowByte = pwdata[7:0];
    wire dataBit1 = pwdata[1];
    property p_readyPulse;
        pready |=> !pready;
    endproperty
    a_readyPulse: assert property (p_readyPulse) else $error("pready held longer than one cycle");
    property p_oneWait;
        psel && penable && !pready |=> pready;
    endproperty
    a_oneWait: assert property (p_oneWait) else $error("access not answered after one wait");
    property p_setupQuiet;
        psel && !penable |-> !pready && !pslverr;
    endproperty
    a_setupQuiet: assert property (p_setupQuiet) else $error("answer during setup cycle");
    property p_dataQuiet;
        prdata[31:8] == 24'h0 && (pready || prdata == 32'h0);
    endproperty
    a_dataQuiet: assert property (p_dataQuiet) else $error("read data outside its cycle");
    property p_errWithReady;
        pslverr |-> pready && prdata == 32'h0;
    endproperty
    a_errWithReady: assert property (p_errWithReady) else $error("error without ready or with data");
    property p_resetClear;
        $past(reset) |-> !pinIrqReq && !irq && priorityLowOut == 8'h00 && pinIrqPriority == 2'h0;
    endproperty
    a_resetClear: assert property (p_resetClear) else $error("outputs not clear after reset");
    property p_prioLow;
        wrDone && paddr == `PCI_ADDR_PRIO_LOW |-> ##2 priorityLowOut == $past(lowByte, 2)
            && pinIrqPriority[0] == $past(dataBit1, 2);
    endproperty
    a_prioLow: assert property (p_prioLow) else $error("priority low byte not taken");
    property p_prioHigh;
        wrDone && paddr == `PCI_ADDR_PRIO_HIGH |-> ##2 pinIrqPriority[1] == $past(dataBit1, 2);
    endproperty
    a_prioHigh: assert property (p_prioHigh) else $error("priority high bit not taken");
endmodule

bind pci_top pci_top_sva u_sva (
    .clk(clk),
    .reset(reset),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .pinIrqReq(pinIrqReq),
    .pinIrqPriority(pinIrqPriority),
    .priorityLowOut(priorityLowOut),
    .irq(irq)
);

// [test/pci_pin_model.sv]
// external circuitry driving the four candidate ports
module pci_pin_model (
    input wire clk,
    input wire load,
    input wire [1:0] portSel,
    input wire [7:0] value,
    output reg [7:0] port0Pins,
    output reg [7:0] port1Pins,
    output reg [7:0] port2Pins,
    output reg [7:0] port3Pins
);
    timeunit 1ns;
    timeprecision 1ns;
    // other ports take the inverse, so a wrong port pick shows in the flags
    always @(posedge clk) begin
        if (load) begin
            port0Pins <= (portSel == 2'h0) ? value : ~value;
            port1Pins <= (portSel == 2'h1) ? value : ~value;
            port2Pins <= (portSel == 2'h2) ? value : ~value;
            port3Pins <= (portSel == 2'h3) ? value : ~value;
        end
    end
endmodule

// [test/test_pin_change_interrupt.sv]
// self-checking bench for the pin change interrupt unit
`include "pci_regs.vh"
module test_pin_change_interrupt;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [7:0] ctl, neg, pos, pins, flags; logic req;} pci_row_t;
    logic clk, reset, psel, penable, pwrite, ld;
    logic [11:0] paddr;
    logic [31:0] pwdata, v;
    logic [1:0] sel;
    logic [7:0] val;
    wire [31:0] prdata;
    wire pready, pslverr, pinIrqReq, irq;
    wire [1:0] pinIrqPriority;
    wire [7:0] priorityLowOut, p0, p1, p2, p3;
    int n_errors = 0;
    int check_count = 0;
    // level mode rows, one per port code
    pci_row_t rows [4] = '{'{8'h00, 8'hFF, 8'h00, 8'h0F, 8'hF0, 1'h1}, '{8'h01, 8'h00, 8'h00, 8'hA5, 8'h5A, 1'h0},
        '{8'h02, 8'h00, 8'h0F, 8'hF0, 8'h0F, 1'h0}, '{8'h03, 8'h00, 8'h81, 8'h80, 8'h7F, 1'h1}};
    logic [11:0] regs [5] = '{`PCI_ADDR_CONTROL, `PCI_ADDR_NEG_EN, `PCI_ADDR_POS_EN, `PCI_ADDR_FLAGS,
        `PCI_ADDR_PRIO_LOW};
    pci_top dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .port0Pins(p0), .port1Pins(p1),
        .port2Pins(p2), .port3Pins(p3), .pinIrqReq(pinIrqReq), .pinIrqPriority(pinIrqPriority),
        .priorityLowOut(priorityLowOut), .irq(irq));
    pci_pin_model pins_far (.clk(clk), .load(ld), .portSel(sel), .value(val), .port0Pins(p0), .port1Pins(p1),
        .port2Pins(p2), .port3Pins(p3));
    // clock and time zero values
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    initial begin
        // 59 bits on both sides, so reset really starts high
        {reset, psel, penable, pwrite, ld, sel, val, paddr, pwdata} = {1'h1, 6'h0, 8'hFF, 12'h0, 32'h0};
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== {24'h0, exp}) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one apb transfer, request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d, output logic [31:0] r,
        output logic e);
        int n;
        n = 0;
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'h1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (n >= 20) n_errors++;
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'h1, a, d, r, e);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        logic e;
        apb(1'h0, a, 8'h00, r, e);
    endtask
    // new pin value, then time for the two sync flops and the flag
    task automatic pins(input logic [1:0] p, input logic [7:0] x);
        ld <= 1'h1;
        sel <= p;
        val <= x;
        @(posedge clk);
        ld <= 1'h0;
        repeat (6) @(posedge clk);
    endtask
    // pins high so level flags read zero too
    task automatic rst_chk;
        pins(2'h0, 8'hFF);
        reset <= 1'h1;
        repeat (10) @(posedge clk);
        reset <= 1'h0;
        repeat (4) @(posedge clk);
        foreach (regs[i]) begin
            rd(regs[i], v);
            chk("reset value", 8'h00, v);
        end
        $display("test reset done");
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #(40 * 5000);
        n_errors++;
        results();
    end
    logic [31:0] r;
    logic e;
    initial begin
        @(posedge clk);
        rst_chk();
        foreach (rows[i]) begin
            wr(`PCI_ADDR_CONTROL, rows[i].ctl);
            wr(`PCI_ADDR_NEG_EN, rows[i].neg);
            wr(`PCI_ADDR_POS_EN, rows[i].pos);
            pins(rows[i].ctl[1:0], rows[i].pins);
            rd(`PCI_ADDR_FLAGS, v);
            chk("level flags", rows[i].flags, v);
            chk("level request", {7'h0, rows[i].req}, {31'h0, pinIrqReq});
        end
        $display("test rows done");
        // edge mode on every channel of port 0
        pins(2'h0, 8'h00);
        wr(`PCI_ADDR_CONTROL, 8'hFC);
        wr(`PCI_ADDR_POS_EN, 8'h01);
        wr(`PCI_ADDR_NEG_EN, 8'h02);
        wr(`PCI_ADDR_FLAGS, 8'h00);
        wr(`PCI_ADDR_IRQ_CLEAR, 8'hFF);
        wr(`PCI_ADDR_IRQ_ENABLE, 8'h00);
        pins(2'h0, 8'h01);
        rd(`PCI_ADDR_FLAGS, v);
        chk("rising flag", 8'h01, v);
        pins(2'h0, 8'h03);
        rd(`PCI_ADDR_FLAGS, v);
        chk("disabled rise", 8'h01, v);
        pins(2'h0, 8'h01);
        rd(`PCI_ADDR_FLAGS, v);
        chk("falling flag", 8'h03, v);
        chk("edge request", 8'h01, {31'h0, pinIrqReq});
        rd(`PCI_ADDR_IRQ_STATUS, v);
        chk("status", 8'h03, v);
        chk("irq masked", 8'h00, {31'h0, irq});
        wr(`PCI_ADDR_IRQ_ENABLE, 8'h01);
        repeat (2) @(posedge clk);
        chk("irq enabled", 8'h01, {31'h0, irq});
        wr(`PCI_ADDR_IRQ_CLEAR, 8'h01);
        repeat (2) @(posedge clk);
        rd(`PCI_ADDR_IRQ_STATUS, v);
        chk("status cleared", 8'h02, v);
        chk("irq cleared", 8'h00, {31'h0, irq});
        wr(`PCI_ADDR_FLAGS, 8'h00);
        rd(`PCI_ADDR_FLAGS, v);
        chk("software clear", 8'h00, v);
        chk("request gone", 8'h00, {31'h0, pinIrqReq});
        wr(`PCI_ADDR_FLAGS, 8'h04);
        rd(`PCI_ADDR_FLAGS, v);
        chk("software set", 8'h04, v);
        wr(`PCI_ADDR_CONTROL, 8'h00);
        wr(`PCI_ADDR_FLAGS, 8'h00);
        rd(`PCI_ADDR_FLAGS, v);
        chk("level write ignored", 8'hFE, v);
        // shared type bits: a grouped pair and one single channel take the software clear
        wr(`PCI_ADDR_CONTROL, 8'h84);
        wr(`PCI_ADDR_FLAGS, 8'h00);
        rd(`PCI_ADDR_FLAGS, v);
        chk("type ch67 and ch0", 8'h3E, v);
        wr(`PCI_ADDR_CONTROL, 8'h48);
        wr(`PCI_ADDR_FLAGS, 8'h00);
        rd(`PCI_ADDR_FLAGS, v);
        chk("type ch45 and ch1", 8'hCC, v);
        $display("test edge done");
        // priority bits
        wr(`PCI_ADDR_PRIO_LOW, 8'hA5);
        rd(`PCI_ADDR_PRIO_LOW, v);
        chk("prio low", 8'hA5, v);
        chk("prio out", 8'hA5, {24'h0, priorityLowOut});
        chk("prio level", 8'h00, {30'h0, pinIrqPriority});
        wr(`PCI_ADDR_PRIO_LOW, 8'h5A);
        wr(`PCI_ADDR_PRIO_HIGH, 8'h02);
        // level output is registered one edge after the write lands
        @(posedge clk);
        chk("prio level both", 8'h03, {30'h0, pinIrqPriority});
        apb(1'h0, 12'h004, 8'h00, r, e);
        chk("unmapped error", 8'h01, {31'h0, e});
        chk("unmapped data", 8'h00, r);
        $display("test priority done");
        rst_chk();
        results();
    end
endmodule
